// ===== inc/rdh_pkg.sv
// Constants and carrier types of the routine definition handler
`default_nettype none
package rdh_pkg;
  // ****************************************
  // Characters and names
  // ****************************************
  localparam logic [7:0] CH_APOS = 8'h27;
  localparam logic [7:0] CH_DQUOTE = 8'h22;
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;
  localparam logic [7:0] CH_NULL = 8'h00;
  localparam logic [7:0] CH_NONE = 8'hFF;
  localparam logic [55:0] NAME_SHARED = 56'h474C4F42414C53;
  localparam logic [23:0] NAME_PREFIX = 24'h414C47;
  localparam logic [5:0] SLOT_MAX = 6'h20;
  // ****************************************
  // Memory, error codes, register map
  // ****************************************
  localparam logic [16:0] MEM_WORDS = 17'h0A000;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_TOO_BIG = 16'h0C0D;
  localparam logic [15:0] ERR_BAD_NAME = 16'h0C01;
  localparam logic [15:0] ERR_RUNNING = 16'h0C02;
  localparam logic [15:0] ERR_DEFINED = 16'h0C03;
  localparam logic [15:0] ERR_SWAP_SET = 16'h0C04;
  localparam logic [15:0] ERR_NO_TERM = 16'h0C05;
  localparam logic [15:0] ERR_NO_MEM = 16'h0C06;
  localparam logic [15:0] ERR_SYNTAX = 16'h0C07;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_ERROR = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_CLR = 8'h0C;
  localparam logic [7:0] REG_IRQ_EN = 8'h10;
  localparam logic [7:0] REG_FREE = 8'h14;
  localparam logic [7:0] REG_SLOT_SEL = 8'h18;
  localparam logic [7:0] REG_SLOT_INFO = 8'h1C;
  localparam logic [7:0] REG_CHAN_MASK = 8'h20;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_DELAY = 2;
  localparam logic [2:0] IRQ_EN_RST = 3'h0;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {P_IDLE = 4'h0, P_NAME = 4'h1, P_TYPE = 4'h2, P_QUOTE = 4'h3,
    P_NDIG = 4'h4, P_CNT = 4'h5, P_DATA = 4'h6, P_INDEF = 4'h7, P_COMMIT = 4'h8} rdh_pstate_type;
  typedef struct packed {logic def_start; logic swap_present; logic [15:0] swap_size;
    logic reset; logic arm; logic abort; logic apply;} rdh_cmd_type;
  typedef struct packed {logic valid; logic [7:0] data; logic last;} rdh_byte_type;
  typedef struct packed {logic valid; logic [5:0] slot; logic region; logic keep_vars;} rdh_load_type;
  typedef struct packed {
    rdh_pstate_type ps; logic trig; logic [55:0] name; logic [2:0] nlen; logic [15:0] err;
    logic swp; logic [15:0] swsz; logic [7:0] qch; logic blk; logic [3:0] ndig;
    logic [29:0] cnt; logic [29:0] len; logic [7:0] lastb;
    logic [32:0] defined; logic [32:0] swap_en; logic [32:0] active; logic [32:0] pending;
    logic [32:0][15:0] exec_w; logic [32:0][15:0] swap_w; logic [16:0] free;
    logic [32:0] chan_mask; logic delay_zero; logic [15:0] last_err;
    logic [2:0] irq_stat; logic [2:0] irq_en; logic [5:0] slot_sel;
    logic ack; logic [31:0] rdata; logic in_rdy; logic irq; rdh_load_type load;
  } rdh_state_type;
endpackage
`default_nettype wire

// ===== rtl/rdh_define_handler.sv
// Routine definition handler: parser, slot table, trigger state, bus slave
//
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Slot names ALG1..ALG32 or GLOBALS only, compared case-blind.
// - Swap size reserves twice the requested words.
// - Replacements load into the inactive region; apply switches; regions alternate.
// - Code larger than the swap region gives error 3085.
// - Without swap size reserve exact need; no replacement until reset.
// - Definite block: hash, digit 1-9, that many count digits, then bytes.
// - Block payload must end with a counted null, else termination error.
// - Indefinite block runs until message end carried with the final null.
// - Non-swap slot defined only in trigger idle, else running error.
// - Non-swap slot or shared space defined once per reset.
// - Swap slot, never shared space, redefinable while idle or waiting.
// - Swap size on redefinition is rejected: swapping already enabled.
// - Channel list built only before arming, frozen afterwards, no error.
// - Swap after arming keeps existing variable values.
// - Longer swap after arming forces output delay to zero.
// - Abort returns waiting-for-trigger to idle, other settings kept.
module rdh_define_handler (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Host commands and payload bytes
  input wire rdh_pkg::rdh_cmd_type cmd_i,
  input wire rdh_pkg::rdh_byte_type byte_i,
  output logic byte_ready_o,
  // Results
  output rdh_pkg::rdh_load_type load_o,
  output logic trig_wait_o,
  output logic [32:0] chan_mask_o,
  output logic delay_zero_o,
  output logic irq_o
);
  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic is_digit(input logic [7:0] c);
    is_digit = (c >= rdh_pkg::CH_ZERO) && (c <= rdh_pkg::CH_NINE);
  endfunction

  function automatic logic [7:0] to_upper(input logic [7:0] c);
    to_upper = (c >= 8'h61 && c <= 8'h7A) ? c - 8'h20 : c;
  endfunction

  // Returns {ok, slot}; slot 0 is the shared variable space
  function automatic logic [6:0] slot_decode(input logic [55:0] nm, input logic [2:0] ln);
    logic [7:0] tens;
    logic [7:0] ones;
    logic [7:0] v;
    tens = nm[15:8] - rdh_pkg::CH_ZERO;
    ones = nm[7:0] - rdh_pkg::CH_ZERO;
    v = 8'((tens << 3) + (tens << 1) + ones);
    slot_decode = 7'h00;
    if (ln == 3'h7 && nm == rdh_pkg::NAME_SHARED)
      slot_decode = 7'h40;
    else if (ln == 3'h4 && nm[31:8] == rdh_pkg::NAME_PREFIX && is_digit(nm[7:0]) && ones != 8'h00)
      slot_decode = {1'b1, ones[5:0]};
    else if (ln == 3'h5 && nm[39:16] == rdh_pkg::NAME_PREFIX && is_digit(nm[15:8])
             && is_digit(nm[7:0]) && tens != 8'h00 && v <= {2'h0, rdh_pkg::SLOT_MAX})
      slot_decode = {1'b1, v[5:0]};
  endfunction

  function automatic logic [15:0] first_err(input logic [15:0] cur, input logic [15:0] nw);
    first_err = (cur == rdh_pkg::ERR_NONE) ? nw : cur;
  endfunction

  // ****************************************
  // State
  // ****************************************
  rdh_pkg::rdh_state_type st_q;
  rdh_pkg::rdh_state_type st_d;
  logic take;
  logic [7:0] ch;
  logic [7:0] dsub;
  logic [6:0] res;
  logic [5:0] idx;
  logic ok;
  logic sw;
  logic [15:0] e;
  logic [29:0] need;
  logic [2:0] clr;
  logic [2:0] set;
  logic [31:0] rd;
  logic [5:0] ssel;
  logic [16:0] alloc;

  // Next-state logic: bus, commands, parser, commit
  always_comb
  begin
    st_d = st_q;
    clr = 3'h0;
    set = 3'h0;
    rd = 32'h0;
    take = byte_i.valid & st_q.in_rdy;
    ch = to_upper(byte_i.data);
    dsub = byte_i.data - rdh_pkg::CH_ZERO;
    res = slot_decode(st_q.name, st_q.nlen);
    ok = res[6];
    idx = res[5:0];
    sw = ok & st_q.swap_en[idx];
    e = st_q.err;
    need = st_q.swp ? {13'h0, st_q.swsz, 1'b0} : st_q.len;
    ssel = (st_q.slot_sel <= rdh_pkg::SLOT_MAX) ? st_q.slot_sel : 6'h00;
    alloc = st_q.swap_en[ssel] ? {st_q.swap_w[ssel], 1'b0} : {1'b0, st_q.exec_w[ssel]};
    st_d.ack = 1'b0;
    st_d.load.valid = 1'b0;
    // Register reads; unmapped offsets answer zero
    case (wb_adr_i)
      rdh_pkg::REG_STATUS: rd = {28'h0, st_q.delay_zero, st_q.ps != rdh_pkg::P_IDLE, st_q.irq, st_q.trig};
      rdh_pkg::REG_ERROR: rd = {16'h0, st_q.last_err};
      rdh_pkg::REG_IRQ_STAT: rd = {29'h0, st_q.irq_stat};
      rdh_pkg::REG_IRQ_EN: rd = {29'h0, st_q.irq_en};
      rdh_pkg::REG_FREE: rd = {15'h0, st_q.free};
      rdh_pkg::REG_SLOT_SEL: rd = {26'h0, st_q.slot_sel};
      rdh_pkg::REG_SLOT_INFO: rd = (st_q.slot_sel <= rdh_pkg::SLOT_MAX) ? {st_q.defined[ssel],
        st_q.swap_en[ssel], st_q.active[ssel], st_q.pending[ssel], 11'h0, alloc} : 32'h0;
      rdh_pkg::REG_CHAN_MASK: rd = st_q.chan_mask[32:1];
      default: rd = 32'h0;
    endcase
    // One-wait-state answer; writes land on the acking edge's request
    if (wb_cyc_i && wb_stb_i && !st_q.ack)
    begin
      st_d.ack = 1'b1;
      st_d.rdata = wb_we_i ? 32'h0 : rd;
      if (wb_we_i && wb_sel_i[0])
      begin
        case (wb_adr_i)
          rdh_pkg::REG_IRQ_CLR: clr = wb_dat_i[2:0];
          rdh_pkg::REG_IRQ_EN: st_d.irq_en = wb_dat_i[2:0];
          rdh_pkg::REG_SLOT_SEL: st_d.slot_sel = wb_dat_i[5:0];
          default: clr = 3'h0;
        endcase
      end
    end
    // Apply flips every slot with a loaded replacement
    if (cmd_i.apply)
    begin
      for (int i = 0; i <= 32; i++)
      begin
        if (st_q.pending[i])
        begin
          st_d.active[i] = ~st_q.active[i];
          st_d.pending[i] = 1'b0;
        end
      end
    end
    // Abort wins over arm; other trigger settings untouched
    if (cmd_i.abort)
      st_d.trig = 1'b0;
    else if (cmd_i.arm)
      st_d.trig = 1'b1;
    // Payload parser
    case (st_q.ps)
      rdh_pkg::P_IDLE:
      begin
        if (cmd_i.def_start)
        begin
          st_d.ps = rdh_pkg::P_NAME;
          st_d.swp = cmd_i.swap_present;
          st_d.swsz = cmd_i.swap_size;
          st_d.name = 56'h0;
          st_d.nlen = 3'h0;
          st_d.err = rdh_pkg::ERR_NONE;
        end
      end
      rdh_pkg::P_NAME:
      begin
        // Quote marks around the name are skipped
        if (take && byte_i.data == rdh_pkg::CH_COMMA)
          st_d.ps = rdh_pkg::P_TYPE;
        else if (take && byte_i.data != rdh_pkg::CH_APOS && byte_i.data != rdh_pkg::CH_DQUOTE)
        begin
          if (st_q.nlen == 3'h7)
            st_d.err = first_err(st_q.err, rdh_pkg::ERR_BAD_NAME);
          else
          begin
            st_d.name = {st_q.name[47:0], ch};
            st_d.nlen = st_q.nlen + 3'h1;
          end
        end
      end
      rdh_pkg::P_TYPE:
      begin
        st_d.len = 30'h0;
        st_d.lastb = rdh_pkg::CH_NONE;
        if (take && (byte_i.data == rdh_pkg::CH_APOS || byte_i.data == rdh_pkg::CH_DQUOTE))
        begin
          st_d.qch = byte_i.data;
          st_d.blk = 1'b0;
          st_d.ps = rdh_pkg::P_QUOTE;
        end
        else if (take && byte_i.data == rdh_pkg::CH_HASH)
        begin
          st_d.blk = 1'b1;
          st_d.ps = rdh_pkg::P_NDIG;
        end
        else if (take)
        begin
          st_d.err = first_err(st_q.err, rdh_pkg::ERR_SYNTAX);
          st_d.ps = rdh_pkg::P_COMMIT;
        end
      end
      rdh_pkg::P_QUOTE:
      begin
        // A quoted string needs no null terminator
        if (take && byte_i.data == st_q.qch)
          st_d.ps = rdh_pkg::P_COMMIT;
        else if (take)
          st_d.len = st_q.len + 30'h1;
      end
      rdh_pkg::P_NDIG:
      begin
        if (take && byte_i.data == rdh_pkg::CH_ZERO)
          st_d.ps = rdh_pkg::P_INDEF;
        else if (take && is_digit(byte_i.data))
        begin
          st_d.ndig = dsub[3:0];
          st_d.cnt = 30'h0;
          st_d.ps = rdh_pkg::P_CNT;
        end
        else if (take)
        begin
          st_d.err = first_err(st_q.err, rdh_pkg::ERR_SYNTAX);
          st_d.ps = rdh_pkg::P_COMMIT;
        end
      end
      rdh_pkg::P_CNT:
      begin
        if (take && is_digit(byte_i.data))
        begin
          st_d.cnt = 30'({st_q.cnt, 3'h0} + {st_q.cnt, 1'b0} + {25'h0, dsub});
          st_d.ndig = st_q.ndig - 4'h1;
          if (st_q.ndig == 4'h1)
            st_d.ps = (st_d.cnt == 30'h0) ? rdh_pkg::P_COMMIT : rdh_pkg::P_DATA;
        end
        else if (take)
        begin
          st_d.err = first_err(st_q.err, rdh_pkg::ERR_SYNTAX);
          st_d.ps = rdh_pkg::P_COMMIT;
        end
      end
      rdh_pkg::P_DATA:
      begin
        if (take)
        begin
          st_d.len = st_q.len + 30'h1;
          st_d.lastb = byte_i.data;
          st_d.cnt = st_q.cnt - 30'h1;
          if (st_q.cnt == 30'h1)
            st_d.ps = rdh_pkg::P_COMMIT;
        end
      end
      rdh_pkg::P_INDEF:
      begin
        // Everything up to the end marker is taken as code
        if (take)
        begin
          st_d.len = st_q.len + 30'h1;
          st_d.lastb = byte_i.data;
          if (byte_i.last)
            st_d.ps = rdh_pkg::P_COMMIT;
        end
      end
      rdh_pkg::P_COMMIT:
      begin
        st_d.ps = rdh_pkg::P_IDLE;
        if (st_q.blk && st_q.lastb != rdh_pkg::CH_NULL)
          e = first_err(e, rdh_pkg::ERR_NO_TERM);
        if (!ok)
          e = first_err(e, rdh_pkg::ERR_BAD_NAME);
        else if (idx == 6'h00 && st_q.swp)
          e = first_err(e, rdh_pkg::ERR_SYNTAX);
        if (e == rdh_pkg::ERR_NONE)
        begin
          if (!sw && st_q.trig)
            e = rdh_pkg::ERR_RUNNING;
          else if (!sw && st_q.defined[idx])
            e = rdh_pkg::ERR_DEFINED;
          else if (sw && st_q.swp)
            e = rdh_pkg::ERR_SWAP_SET;
          else if (sw && st_q.len > {14'h0, st_q.swap_w[idx]})
            e = rdh_pkg::ERR_TOO_BIG;
          else if (!sw && st_q.swp && st_q.len > {14'h0, st_q.swsz})
            e = rdh_pkg::ERR_TOO_BIG;
          else if (!sw && need > {13'h0, st_q.free})
            e = rdh_pkg::ERR_NO_MEM;
        end
        st_d.last_err = e;
        if (e != rdh_pkg::ERR_NONE)
          set[rdh_pkg::IRQ_ERR] = 1'b1;
        else
        begin
          set[rdh_pkg::IRQ_DONE] = 1'b1;
          st_d.load.valid = 1'b1;
          st_d.load.slot = idx;
          st_d.load.keep_vars = st_q.trig;
          if (sw)
          begin
            st_d.load.region = ~st_d.active[idx];
            st_d.pending[idx] = 1'b1;
            if (st_q.trig && st_q.len > {14'h0, st_q.exec_w[idx]})
            begin
              st_d.delay_zero = 1'b1;
              set[rdh_pkg::IRQ_DELAY] = 1'b1;
            end
            else if (!st_q.trig && st_q.len > {14'h0, st_q.exec_w[idx]})
              st_d.exec_w[idx] = st_q.len[15:0];
          end
          else
          begin
            // Shared space payload holds declarations only; host keeps names apart
            st_d.load.region = 1'b0;
            st_d.defined[idx] = 1'b1;
            st_d.swap_en[idx] = st_q.swp;
            st_d.swap_w[idx] = st_q.swsz;
            st_d.exec_w[idx] = st_q.len[15:0];
            st_d.free = st_q.free - need[16:0];
            st_d.chan_mask[idx] = 1'b1;
            st_d.active[idx] = 1'b0;
            st_d.pending[idx] = 1'b0;
          end
        end
      end
      default: st_d.ps = rdh_pkg::P_IDLE;
    endcase
    // Message ending early closes the definition as a syntax error
    if (take && byte_i.last && st_d.ps != rdh_pkg::P_COMMIT && st_d.ps != rdh_pkg::P_IDLE)
    begin
      st_d.err = first_err(st_d.err, rdh_pkg::ERR_SYNTAX);
      st_d.ps = rdh_pkg::P_COMMIT;
    end
    // Reset command clears every routine and the trigger state
    if (cmd_i.reset)
    begin
      st_d.ps = rdh_pkg::P_IDLE;
      st_d.trig = 1'b0;
      st_d.defined = 33'h0;
      st_d.swap_en = 33'h0;
      st_d.active = 33'h0;
      st_d.pending = 33'h0;
      st_d.chan_mask = 33'h0;
      st_d.exec_w = '0;
      st_d.swap_w = '0;
      st_d.free = rdh_pkg::MEM_WORDS;
      st_d.delay_zero = 1'b0;
      st_d.load.valid = 1'b0;
    end
    // Sticky events: a new event beats a clear in the same cycle
    st_d.irq_stat = (st_q.irq_stat & ~clr) | set;
    st_d.irq = |(st_d.irq_stat & st_d.irq_en);
    st_d.in_rdy = (st_d.ps != rdh_pkg::P_IDLE) && (st_d.ps != rdh_pkg::P_COMMIT);
  end

  // State register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
      st_q.free <= rdh_pkg::MEM_WORDS;
      st_q.irq_en <= rdh_pkg::IRQ_EN_RST;
    end
    else
      st_q <= st_d;
  end

  // Outputs straight from the state register
  assign wb_dat_o = st_q.rdata;
  assign wb_ack_o = st_q.ack;
  assign byte_ready_o = st_q.in_rdy;
  assign load_o = st_q.load;
  assign trig_wait_o = st_q.trig;
  assign chan_mask_o = st_q.chan_mask;
  assign delay_zero_o = st_q.delay_zero;
  assign irq_o = st_q.irq;

  // ****************************************
  // Assertions
  // ****************************************
  a_ack_pulse:
    assert property (@(posedge clock) disable iff (!rst_n) wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_answer:
    assert property (@(posedge clock) disable iff (!rst_n) wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  a_irq_level:
    assert property (@(posedge clock) disable iff (!rst_n) irq_o == |(st_q.irq_stat & st_q.irq_en))
    else $error("interrupt does not follow enabled status");
  a_shared_noswap:
    assert property (@(posedge clock) disable iff (!rst_n) !st_q.swap_en[0])
    else $error("shared space became swap enabled");
  a_armed_load_swap:
    assert property (@(posedge clock) disable iff (!rst_n) load_o.valid && load_o.keep_vars |-> st_q.swap_en[load_o.slot])
    else $error("non-swap slot loaded while armed");
  a_chan_frozen:
    assert property (@(posedge clock) disable iff (!rst_n) st_q.trig && $past(st_q.trig) |-> $stable(chan_mask_o))
    else $error("channel list changed while armed");
  a_abort_idle:
    assert property (@(posedge clock) disable iff (!rst_n) cmd_i.abort |=> !trig_wait_o)
    else $error("abort did not return to idle");
  a_keep_vars:
    assert property (@(posedge clock) disable iff (!rst_n) load_o.valid |-> load_o.keep_vars == $past(st_q.trig))
    else $error("variable keep flag wrong");
  a_fit_swap:
    assert property (@(posedge clock) disable iff (!rst_n) load_o.valid && st_q.swap_en[load_o.slot]
      |-> st_q.len <= {14'h0, st_q.swap_w[load_o.slot]})
    else $error("oversized code accepted");
  a_load_clean:
    assert property (@(posedge clock) disable iff (!rst_n) load_o.valid |-> st_q.last_err == rdh_pkg::ERR_NONE)
    else $error("load issued with an error recorded");
  a_free_bound:
    assert property (@(posedge clock) disable iff (!rst_n) st_q.free <= rdh_pkg::MEM_WORDS)
    else $error("free words above memory size");
endmodule // rdh_define_handler
`default_nettype wire

// ===== verification/rdh_host_model.sv
// Host controller model: sends commands and payload bytes to the handler
`timescale 1ns/1ps
`default_nettype none
module rdh_host_model (
  // Clock
  input wire logic clock,
  // Commands and payload
  output var rdh_pkg::rdh_cmd_type cmd_o,
  output var rdh_pkg::rdh_byte_type byte_o,
  // Flow control
  input wire logic byte_ready_i
);
  // Quiet lines from time zero
  initial
  begin
    cmd_o = '0;
    byte_o = '0;
  end
  // One-cycle command: 0 reset, 1 arm, 2 abort, 3 apply
  task automatic pulse(input int c);
    @(posedge clock);
    cmd_o.reset <= c == 0;
    cmd_o.arm <= c == 1;
    cmd_o.abort <= c == 2;
    cmd_o.apply <= c == 3;
    @(posedge clock);
    cmd_o <= '0;
  endtask
  // Each byte is held until an edge sees ready; a stalled handler ends the wait
  task automatic send(input logic [7:0] q[$], input logic sw, input logic [15:0] sz, output logic ok);
    int n;
    ok = 1'b1;
    @(posedge clock);
    cmd_o.def_start <= 1'b1;
    cmd_o.swap_present <= sw;
    cmd_o.swap_size <= sz;
    @(posedge clock);
    cmd_o <= '0;
    foreach (q[i])
    begin
      byte_o <= '{1'b1, q[i], i == q.size() - 1};
      n = 0;
      do
      begin
        @(posedge clock);
        n++;
      end
      while (byte_ready_i !== 1'b1 && n < 40);
      if (byte_ready_i !== 1'b1) ok = 1'b0;
    end
    // Released data shows the inverse so a stale byte cannot pass
    byte_o.valid <= 1'b0;
    byte_o.last <= 1'b0;
    byte_o.data <= ~byte_o.data;
  endtask
endmodule // rdh_host_model
`default_nettype wire

// ===== verification/tb.sv
// Testbench: definitions, trigger commands and register accesses
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, rdy, tw, dz, irq;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h00000000, rdat, r;
  rdh_pkg::rdh_cmd_type cmd;
  rdh_pkg::rdh_byte_type bt;
  rdh_pkg::rdh_load_type ld;
  logic [32:0] cm, defd, swp, act, pend, emask;
  logic armed, edz;
  int swsz[33], maxw[33];
  int bad_count = 0;
  int n_compared = 0;
  int s;
  string p;
  // Clock
  always #10 clock = ~clock;
  rdh_define_handler i_rdh_define_handler (.clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .cmd_i(cmd), .byte_i(bt), .byte_ready_o(rdy), .load_o(ld), .trig_wait_o(tw), .chan_mask_o(cm),
    .delay_zero_o(dz), .irq_o(irq));
  rdh_host_model i_rdh_host_model (.clock(clock), .cmd_o(cmd), .byte_o(bt), .byte_ready_i(rdy));
  // Verdict and end of run
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // A wait that ran out counts as a mismatch
  task automatic hang();
    bad_count++;
    close_out();
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Classic single cycle; read data taken at the ack edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) hang();
  endtask
  // Expected outcome from the bench's own slot table
  function automatic logic [15:0] exp_err(int sl, logic sw, int sz, int w, int k);
    if (sl < 0) return rdh_pkg::ERR_BAD_NAME;
    if (k == 2) return rdh_pkg::ERR_NO_TERM;
    if (swp[sl]) return sw ? rdh_pkg::ERR_SWAP_SET : (w > swsz[sl] ? rdh_pkg::ERR_TOO_BIG : rdh_pkg::ERR_NONE);
    if (armed) return rdh_pkg::ERR_RUNNING;
    if (defd[sl]) return rdh_pkg::ERR_DEFINED;
    return (sw && w > sz) ? rdh_pkg::ERR_TOO_BIG : rdh_pkg::ERR_NONE;
  endfunction
  // Kind: 0 quoted, 1 definite, 2 definite without null, 3 indefinite
  task automatic def(input string nm, input int sl, input logic sw, input int sz, input string pl, input int k);
    logic [7:0] q[$];
    logic ok;
    logic [15:0] e;
    int w;
    string c;
    w = pl.len() + (k == 1 || k == 3);
    e = exp_err(sl, sw, sz, w, k);
    c = $sformatf("%0d", k == 1 ? w : pl.len());
    for (int i = 0; i < nm.len(); i++) q.push_back(nm[i]);
    q.push_back(rdh_pkg::CH_COMMA);
    q.push_back(k == 0 ? rdh_pkg::CH_APOS : rdh_pkg::CH_HASH);
    if (k == 3) q.push_back(rdh_pkg::CH_ZERO);
    if (k == 1 || k == 2) q.push_back(rdh_pkg::CH_ZERO + 8'(c.len()));
    if (k == 1 || k == 2) for (int i = 0; i < c.len(); i++) q.push_back(c[i]);
    for (int i = 0; i < pl.len(); i++) q.push_back(pl[i]);
    if (k == 0) q.push_back(rdh_pkg::CH_APOS);
    if (k == 1 || k == 3) q.push_back(rdh_pkg::CH_NULL);
    i_rdh_host_model.send(q, sw, 16'(sz), ok);
    if (!ok) hang();
    // Load pulse stands only in the cycle after the commit edge
    @(posedge clock);
    #1;
    chk(ld.valid, e == rdh_pkg::ERR_NONE);
    if (e == rdh_pkg::ERR_NONE)
    begin
      chk({ld.slot, ld.region, ld.keep_vars}, {6'(sl), defd[sl] ^ act[sl], armed});
      pend[sl] = defd[sl];
      edz = edz | (armed && w > maxw[sl]);
      if (!armed) emask[sl] = 1'b1;
      if (!armed && w > maxw[sl]) maxw[sl] = w;
      if (!defd[sl]) swp[sl] = sw;
      if (!defd[sl]) swsz[sl] = sz;
      defd[sl] = 1'b1;
    end
    chk(dz, edz);
    chk(cm[32:1], emask[32:1]);
    wb(1'b0, rdh_pkg::REG_ERROR, 32'h0);
    chk(r[15:0], e);
  endtask
  // Trigger commands and their effect on the bench table
  task automatic cmdp(input int c);
    i_rdh_host_model.pulse(c);
    if (c == 0) {defd, swp, act, pend, emask, armed, edz} = '0;
    if (c == 1 || c == 2) armed = c == 1;
    if (c == 3) act = act ^ pend;
    if (c == 3) pend = '0;
    @(posedge clock);
    #1;
    chk(tw, armed);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {defd, swp, act, pend, emask, armed, edz} = '0;
    r = $urandom(73);
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    wb(1'b0, rdh_pkg::REG_FREE, 32'h0);
    chk(r, 32'h0000A000);
    wb(1'b1, 8'h40, 32'hFFFFFFFF);
    wb(1'b0, 8'h40, 32'h0);
    chk(r, 32'h00000000);
    wb(1'b1, rdh_pkg::REG_IRQ_EN, 32'h00000007);
    def("globals", 0, 1'b0, 0, "static float v;", 0);
    chk(irq, 1'b1);
    wb(1'b1, rdh_pkg::REG_IRQ_EN, 32'h0);
    wb(1'b0, rdh_pkg::REG_IRQ_STAT, 32'h0);
    chk(r, 32'h00000001);
    chk(irq, 1'b0);
    wb(1'b1, rdh_pkg::REG_IRQ_CLR, 32'h00000007);
    wb(1'b1, rdh_pkg::REG_IRQ_EN, 32'h00000007);
    wb(1'b0, rdh_pkg::REG_IRQ_STAT, 32'h0);
    chk(r, 32'h0);
    chk(irq, 1'b0);
    def("GLOBALS", 0, 1'b0, 0, "float w;", 0);
    def("ALG33", -1, 1'b0, 0, "x", 0);
    def("ALG0", -1, 1'b0, 0, "x", 0);
    def("ALG1", 1, 1'b0, 0, "a=b;", 1);
    def("ALG2", 2, 1'b0, 0, "abc", 2);
    def("ALG4", 4, 1'b1, 2, "abc", 0);
    def("Alg3", 3, 1'b1, 8, "ab", 1);
    wb(1'b1, rdh_pkg::REG_SLOT_SEL, 32'h3);
    wb(1'b0, rdh_pkg::REG_SLOT_INFO, 32'h0);
    chk({r[31:30], r[16:0]}, {2'b11, 17'h00010});
    cmdp(1);
    def("ALG5", 5, 1'b0, 0, "x", 0);
    def("ALG3", 3, 1'b0, 0, "abcdefg", 0);
    def("ALG3", 3, 1'b1, 8, "ab", 0);
    def("ALG3", 3, 1'b0, 0, "abcdefghi", 0);
    cmdp(3);
    def("ALG3", 3, 1'b0, 0, "xy", 0);
    cmdp(2);
    def("ALG1", 1, 1'b0, 0, "ab", 0);
    cmdp(0);
    def("ALG1", 1, 1'b0, 0, "ab", 3);
    repeat (6)
    begin
      s = $urandom_range(1, 32);
      p = "";
      repeat ($urandom_range(1, 5)) p = $sformatf("%s%c", p, 8'($urandom_range(97, 122)));
      def($sformatf("%s%0d", $urandom_range(0, 1) ? "alg" : "ALG", s), s, 1'b0, 0, p, $urandom_range(0, 1));
    end
    // Mid-run hardware reset must restore the full memory and empty channel list
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    wb(1'b0, rdh_pkg::REG_FREE, 32'h0);
    chk(r, 32'h0000A000);
    chk(cm[32:1], 32'h0);
    close_out();
  end
endmodule // tb
`default_nettype wire
